/* ctl_port_consts.vh */
// Constants for the two-wire codec control port target.
// Included by the target module; holds definitions only.
`ifndef CTL_PORT_CONSTS_VH
`define CTL_PORT_CONSTS_VH

// ==========================================
// Bus identity and register map
`define TARGET_ADDR 7'h10
`define LAST_REG 8'h1c
`define REG_COUNT 29
`define REG_RESET 8'h00
`define PTR_RESET 8'h00

// ==========================================
// Serial clock limit, for reference against sampling delay
`define FSCL_MAX_KHZ 400
`define CORE_CLK_MHZ 200

// ==========================================
// Target states
`define ST_IDLE 3'h0
`define ST_RX 3'h1
`define ST_ACK 3'h2
`define ST_TX 3'h3
`define ST_RACK 3'h4

// ==========================================
// Kind of byte being received
`define KIND_ADDR 2'h0
`define KIND_PTR 2'h1
`define KIND_DATA 2'h2

`endif

/* codec_i2c_control_slave.v */
// Two-wire control port target of the codec, with its configuration registers.
// Assumes external pull-ups on both lines and a core clock far faster than the bus clock.
`timescale 1ns/10ps
`default_nettype none
`include "ctl_port_consts.vh"

module codec_i2c_control_slave (
   input wire core_clk,
   input wire srst,
   input wire scl_in,
   input wire sda_in,
   output wire sda_out,
   output wire sda_oe,
   output wire busy,
   output reg wr_pulse,
   output reg [7:0] wr_addr,
   output reg [7:0] wr_data,
   input wire [4:0] cfg_rd_addr,
   output reg [7:0] cfg_rd_data
);

   // ==========================================
   // Helpers
   function in_map;
      input [7:0] a;
      begin
         in_map = (a <= `LAST_REG);
      end
   endfunction

   // ==========================================
   // Pin synchronisers and condition detection
   // Sampling delay is a few core cycles, far below the shortest clock-high time at 400kHz
   reg scl_s1_reg, scl_s2_reg, scl_d_reg;
   reg sda_s1_reg, sda_s2_reg, sda_d_reg;
   wire scl_rise = scl_s2_reg & ~scl_d_reg;
   wire scl_fall = ~scl_s2_reg & scl_d_reg;
   wire scl_high = scl_s2_reg & scl_d_reg;
   wire start_det = scl_high & sda_d_reg & ~sda_s2_reg;
   wire stop_raw = scl_high & ~sda_d_reg & sda_s2_reg;
   reg start_pulse_reg;
   wire stop_det = stop_raw & ~start_pulse_reg;

   always @(posedge core_clk) begin
      if (srst) begin
         // Idle lines rest high
         scl_s1_reg <= 1'b1;
         scl_s2_reg <= 1'b1;
         scl_d_reg <= 1'b1;
         sda_s1_reg <= 1'b1;
         sda_s2_reg <= 1'b1;
         sda_d_reg <= 1'b1;
      end else begin
         scl_s1_reg <= scl_in;
         scl_s2_reg <= scl_s1_reg;
         scl_d_reg <= scl_s2_reg;
         sda_s1_reg <= sda_in;
         sda_s2_reg <= sda_s1_reg;
         sda_d_reg <= sda_s2_reg;
      end
   end

   // ==========================================
   // Target state machine
   reg [2:0] state_reg;
   reg [3:0] cnt_reg;
   reg [7:0] shift_reg;
   reg [1:0] kind_reg;
   reg rw_reg;
   reg ptr_set_reg;
   reg [7:0] ptr_reg;
   reg oe_reg;
   reg [7:0] regs_mem [0:`REG_COUNT-1];
   wire [7:0] tx_byte = in_map(ptr_reg) ? regs_mem[ptr_reg[4:0]] : 8'h00;
   integer i;

   // Open drain: only ever pull low or release
   assign sda_out = 1'b0;
   assign sda_oe = oe_reg;
   assign busy = (state_reg != `ST_IDLE);

   always @(posedge core_clk) begin
      if (srst) begin
         state_reg <= `ST_IDLE;
         cnt_reg <= 4'h0;
         shift_reg <= 8'h00;
         kind_reg <= `KIND_ADDR;
         rw_reg <= 1'b0;
         ptr_set_reg <= 1'b0;
         ptr_reg <= `PTR_RESET;
         oe_reg <= 1'b0;
         start_pulse_reg <= 1'b0;
         wr_pulse <= 1'b0;
         wr_addr <= 8'h00;
         wr_data <= 8'h00;
         cfg_rd_data <= 8'h00;
         for (i = 0; i < `REG_COUNT; i = i + 1) begin
            regs_mem[i] <= `REG_RESET;
         end
      end else begin
         wr_pulse <= 1'b0;
         cfg_rd_data <= in_map({3'h0, cfg_rd_addr}) ? regs_mem[cfg_rd_addr] : 8'h00;
         if (scl_fall) begin
            start_pulse_reg <= 1'b0;
         end
         if (start_det) begin
            // START or repeated START opens an address phase
            start_pulse_reg <= 1'b1;
            state_reg <= `ST_RX;
            kind_reg <= `KIND_ADDR;
            cnt_reg <= 4'h0;
            oe_reg <= 1'b0;
         end else if (stop_det) begin
            state_reg <= `ST_IDLE;
            oe_reg <= 1'b0;
            ptr_set_reg <= 1'b0;
         end else begin
            case (state_reg)
               `ST_IDLE: begin
                  oe_reg <= 1'b0;
               end
               `ST_RX: begin
                  // Sample on rising clock while the line is stable
                  if (scl_rise) begin
                     shift_reg <= {shift_reg[6:0], sda_s2_reg};
                     cnt_reg <= cnt_reg + 4'h1;
                  end else if (scl_fall && cnt_reg == 4'h8) begin
                     case (kind_reg)
                        `KIND_ADDR: begin
                           if (shift_reg[7:1] == `TARGET_ADDR) begin
                              rw_reg <= shift_reg[0];
                              oe_reg <= 1'b1;
                              state_reg <= `ST_ACK;
                              if (shift_reg[0] && !ptr_set_reg) begin
                                 ptr_reg <= `PTR_RESET;
                              end
                           end else begin
                              state_reg <= `ST_IDLE;
                           end
                        end
                        `KIND_PTR: begin
                           ptr_reg <= shift_reg;
                           ptr_set_reg <= 1'b1;
                           oe_reg <= 1'b1;
                           state_reg <= `ST_ACK;
                        end
                        default: begin
                           // Reserved addresses are acknowledged but not stored
                           if (in_map(ptr_reg)) begin
                              regs_mem[ptr_reg[4:0]] <= shift_reg;
                              wr_pulse <= 1'b1;
                              wr_addr <= ptr_reg;
                              wr_data <= shift_reg;
                           end
                           ptr_reg <= ptr_reg + 8'h01;
                           oe_reg <= 1'b1;
                           state_reg <= `ST_ACK;
                        end
                     endcase
                  end
               end
               `ST_ACK: begin
                  // Release only when the ninth clock falls
                  if (scl_fall) begin
                     cnt_reg <= 4'h0;
                     if (kind_reg == `KIND_ADDR && rw_reg) begin
                        shift_reg <= tx_byte;
                        oe_reg <= ~tx_byte[7];
                        ptr_reg <= ptr_reg + 8'h01;
                        cnt_reg <= 4'h1;
                        state_reg <= `ST_TX;
                     end else begin
                        oe_reg <= 1'b0;
                        kind_reg <= (kind_reg == `KIND_ADDR) ? `KIND_PTR : `KIND_DATA;
                        state_reg <= `ST_RX;
                     end
                  end
               end
               `ST_TX: begin
                  // Data changes only while the clock is low
                  if (scl_fall) begin
                     if (cnt_reg == 4'h8) begin
                        oe_reg <= 1'b0;
                        state_reg <= `ST_RACK;
                     end else begin
                        shift_reg <= {shift_reg[6:0], 1'b0};
                        oe_reg <= ~shift_reg[6];
                        cnt_reg <= cnt_reg + 4'h1;
                     end
                  end
               end
               `ST_RACK: begin
                  if (scl_rise && sda_s2_reg) begin
                     // Not-acknowledge ends the read; wait for STOP or START
                     state_reg <= `ST_IDLE;
                  end else if (scl_fall) begin
                     shift_reg <= tx_byte;
                     oe_reg <= ~tx_byte[7];
                     ptr_reg <= ptr_reg + 8'h01;
                     cnt_reg <= 4'h1;
                     state_reg <= `ST_TX;
                  end
               end
               default: begin
                  state_reg <= `ST_IDLE;
                  oe_reg <= 1'b0;
               end
            endcase
         end
      end
   end

endmodule

`default_nettype wire

/* codec_i2c_control_slave_chk.sv */
// Pin-level checker for the two-wire control port target.
// Bound to the target from the testbench top file; sees only its ports.
`timescale 1ns/10ps
`default_nettype none
module codec_i2c_control_slave_chk (
   input wire logic core_clk,
   input wire logic srst,
   input wire logic scl_in,
   input wire logic sda_in,
   input wire logic sda_out,
   input wire logic sda_oe,
   input wire logic busy,
   input wire logic wr_pulse,
   input wire logic [7:0] wr_addr,
   input wire logic [7:0] wr_data,
   input wire logic [4:0] cfg_rd_addr,
   input wire logic [7:0] cfg_rd_data
);
   // ==========================================
   // Assertions
   default clocking @(posedge core_clk); endclocking
   default disable iff (srst);
   a_drain_only: assert property (!sda_out)
      else $error("data pin driven high");
   a_idle_free: assert property (!busy && $past(!busy) |-> !sda_oe)
      else $error("line held while idle");
   a_oe_scl_low: assert property ($changed(sda_oe) |-> !scl_in)
      else $error("data moved while clock high");
   a_start_seen: assert property (scl_in && $past(scl_in) && $fell(sda_in) |-> ##[1:6] busy)
      else $error("start not taken");
   a_stop_seen: assert property (scl_in && $past(scl_in) && $rose(sda_in) |-> ##[1:6] !busy)
      else $error("stop not taken");
   a_ack_hold: assert property (sda_oe && $rose(scl_in) |-> sda_oe [*6])
      else $error("pull dropped in clock high");
   a_write_acked: assert property (wr_pulse |-> sda_oe && wr_addr <= 8'h1c)
      else $error("bad register write");
   a_pulse_once: assert property (wr_pulse |=> !wr_pulse)
      else $error("write pulse too long");
   a_rd_reserved: assert property (cfg_rd_addr > 5'h1c |=> cfg_rd_data == 8'h00)
      else $error("reserved index not zero");
endmodule
`default_nettype wire

/* i2c_master_model.sv */
// Behavioural two-wire bus master facing the target.
// Pin timing runs free of the core clock; the wire has a pull-up.
`timescale 1ns/10ps
`default_nettype none
module i2c_master_model (
   output logic scl,
   output logic sda_pull,
   input wire logic sda
);
   // ==========================================
   // Bit timing: slow enough for the target's pin synchronisers
   localparam int HALF = 24;
   initial begin
      scl = 1'b1;
      sda_pull = 1'b0;
   end
   task automatic bit_io(input logic b, output logic q);
      #(HALF / 2) sda_pull = !b;
      #(HALF / 2) scl = 1'b1;
      #(HALF) q = sda;
      scl = 1'b0;
   endtask
   task automatic start();
      #(HALF / 2) sda_pull = 1'b0;
      #(HALF / 2) scl = 1'b1;
      #(HALF) sda_pull = 1'b1;
      #(HALF) scl = 1'b0;
   endtask
   task automatic stop();
      #(HALF / 2) sda_pull = 1'b1;
      #(HALF / 2) scl = 1'b1;
      #(HALF) sda_pull = 1'b0;
      #(HALF);
   endtask
   // Nine clocks per byte; a one in tx releases the line, so reads send ones
   task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
      for (int i = 8; i >= 0; i--) begin
         bit_io(tx[i], rx[i]);
      end
   endtask
endmodule
`default_nettype wire

/* codec_i2c_control_slave_test.sv */
// Self-checking testbench for the control port target.
// Assumes the target, its checker and the master model are compiled first.
`timescale 1ns/10ps
`default_nettype none
module codec_i2c_control_slave_test;
   logic core_clk, srst, sda_oe, sda_out, busy, wr_pulse;
   logic [7:0] wr_addr, wr_data, cfg_rd_data;
   logic [4:0] cfg_rd_addr;
   logic [8:0] r;
   logic [15:0] wq[$];
   int mismatches, check_count;
   wire scl, sda_pull, sda;
   // Pull-up wins unless somebody pulls low
   assign sda = !(sda_pull || sda_oe);
   codec_i2c_control_slave i_dut (.core_clk(core_clk), .srst(srst), .scl_in(scl),
      .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe), .busy(busy), .wr_pulse(wr_pulse),
      .wr_addr(wr_addr), .wr_data(wr_data), .cfg_rd_addr(cfg_rd_addr),
      .cfg_rd_data(cfg_rd_data));
   i2c_master_model m (.scl(scl), .sda_pull(sda_pull), .sda(sda));
   initial begin
      core_clk = 1'b0;
      forever #2.5 core_clk = !core_clk;
   end
   // Sampled mid-cycle so the pulse and its data are settled
   always @(negedge core_clk) if (wr_pulse) wq.push_back({wr_addr, wr_data});
   // ==========================================
   // Shared helpers
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      check_count++;
      if (seen !== exp) begin
         mismatches++;
         $display("CHECK FAILED t=%0t seen %h want %h", $time, seen, exp);
      end
   endtask
   task automatic wb(input logic [7:0] d, input logic nack);
      m.xfer({d, 1'b1}, r);
      check(16'(r[0]), 16'(nack));
   endtask
   task automatic rb(input logic [7:0] exp, input logic last);
      m.xfer({8'hff, last}, r);
      check(16'(r[8:1]), 16'(exp));
   endtask
   task automatic wseq(input logic [7:0] b[$], input logic nack);
      m.start();
      foreach (b[i]) wb(b[i], nack);
   endtask
   task automatic fin();
      m.stop();
      for (int i = 0; i < 20 && busy !== 1'b0; i++) @(negedge core_clk);
      check(16'(busy), 16'h0000);
      if (busy !== 1'b0) begin
         summarize();
      end
   endtask
   task automatic wchk(input logic [15:0] e);
      logic [15:0] v;
      v = wq.size() ? wq.pop_front() : 16'hxxxx;
      check(v, e);
   endtask
   // ==========================================
   // Scenarios
   task automatic t_write();
      wseq('{8'h20, 8'h00, 8'h3c, 8'hc3}, 1'b0);
      fin();
      wseq('{8'h20, 8'h1c, 8'h77}, 1'b0);
      fin();
      wchk(16'h003c);
      wchk(16'h01c3);
      wchk(16'h1c77);
      check(16'(wq.size()), 16'h0000);
      cfg_rd_addr = 5'h1d;
      repeat (2) @(negedge core_clk);
      check(16'(cfg_rd_data), 16'h0000);
      cfg_rd_addr = 5'h00;
      repeat (2) @(negedge core_clk);
      check(16'(cfg_rd_data), 16'h003c);
      $display("test write done");
   endtask
   task automatic t_read();
      wseq('{8'h20, 8'h01}, 1'b0);
      fin();
      wseq('{8'h21}, 1'b0);
      rb(8'h3c, 1'b0);
      rb(8'hc3, 1'b1);
      fin();
      wseq('{8'h20, 8'h1c}, 1'b0);
      wseq('{8'h21}, 1'b0);
      rb(8'h77, 1'b0);
      rb(8'h00, 1'b1);
      fin();
      $display("test read done");
   endtask
   task automatic t_foreign();
      logic [7:0] a[$];
      a = '{8'h22, 8'h23, 8'ha0};
      foreach (a[i]) begin
         wseq('{a[i], 8'h05}, 1'b1);
         fin();
      end
      check(16'(wq.size()), 16'h0000);
      $display("test foreign address done");
   endtask
   task automatic t_abort();
      wseq('{8'h20, 8'h05}, 1'b0);
      repeat (4) m.bit_io(1'b0, r[0]);
      fin();
      check(16'(wq.size()), 16'h0000);
      wseq('{8'h20}, 1'b0);
      fin();
      $display("test early stop done");
   endtask
   task automatic summarize();
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   initial begin
      srst = 1'b1;
      cfg_rd_addr = 5'h00;
      mismatches = 0;
      check_count = 0;
      repeat (2) @(negedge core_clk);
      srst = 1'b0;
      repeat (4) @(negedge core_clk);
      t_write();
      t_read();
      t_foreign();
      t_abort();
      summarize();
   end
endmodule
bind codec_i2c_control_slave codec_i2c_control_slave_chk i_chk (.core_clk(core_clk),
   .srst(srst), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
   .busy(busy), .wr_pulse(wr_pulse), .wr_addr(wr_addr), .wr_data(wr_data),
   .cfg_rd_addr(cfg_rd_addr), .cfg_rd_data(cfg_rd_data));
`default_nettype wire
